/* core/agoc_core.v */
`timescale 1ns/1ps
`include "agoc_map.vh"

module agoc_core (
   // clock and reset
   input wire ref_clk,
   input wire resetn,
   // register port
   input wire [15:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // raw conversion stream from the adc
   input wire raw_valid,
   input wire [15:0] raw_result,
   input wire [1:0] raw_chan,
   input wire [2:0] raw_pga,
   // corrected conversion stream
   output reg conversion_result_valid,
   output reg [15:0] conversion_result,
   output reg conversion_saturated
);

   // ****************************************************************
   // calibration and control registers
   // ****************************************************************
   reg [14:0] aux_gain1_gain_cal;
   reg [14:0] aux_gain1_offset_cal;
   reg [14:0] aux_gain1p5_offset_cal;
   reg corr_enable;

   // ****************************************************************
   // status state
   // ****************************************************************
   reg [15:0] last_result;
   reg sat_sticky;
   reg zero_gain_sticky;

   // ****************************************************************
   // address decode
   // ****************************************************************
   wire hit_gain1 = (reg_addr == `AGOC_OFS_GAIN1_GAIN);
   wire hit_off1 = (reg_addr == `AGOC_OFS_GAIN1_OFFSET);
   wire hit_off1p5 = (reg_addr == `AGOC_OFS_GAIN1P5_OFFSET);
   wire hit_status = (reg_addr == `AGOC_OFS_STATUS);
   wire hit_control = (reg_addr == `AGOC_OFS_CONTROL);

   // ****************************************************************
   // correction pipeline wires
   // ****************************************************************
   wire pipe_valid;
   wire [15:0] pipe_result;
   wire pipe_sat;
   wire pipe_zero_gain;

   // ****************************************************************
   // register writes
   // ****************************************************************
   // only the low fifteen bits of a calibration write and bit 0 of a control write are stored; the upper bits have no flops at all
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         aux_gain1_gain_cal <= `AGOC_GAIN_RESET;
         aux_gain1_offset_cal <= `AGOC_OFFSET_RESET;
         aux_gain1p5_offset_cal <= `AGOC_OFFSET_RESET;
         corr_enable <= `AGOC_CTRL_RESET;
      end else if (reg_wr) begin
         if (hit_gain1) begin
            aux_gain1_gain_cal <= reg_wdata[`AGOC_CAL_MSB:0];
         end
         if (hit_off1) begin
            aux_gain1_offset_cal <= reg_wdata[`AGOC_CAL_MSB:0];
         end
         if (hit_off1p5) begin
            aux_gain1p5_offset_cal <= reg_wdata[`AGOC_CAL_MSB:0];
         end
         if (hit_control) begin
            corr_enable <= reg_wdata[`AGOC_CTRL_EN_BIT];
         end
      end
   end

   // ****************************************************************
   // status flags
   // ****************************************************************
   // write one to clear; a new event in the same cycle keeps the flag set
   wire clr_sat = reg_wr && hit_status && reg_wdata[`AGOC_STAT_SAT_BIT];
   wire clr_zero = reg_wr && hit_status && reg_wdata[`AGOC_STAT_ZERO_GAIN_BIT];
   wire set_sat = pipe_valid && pipe_sat;
   wire set_zero = pipe_valid && pipe_zero_gain;

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sat_sticky <= 1'b0;
         zero_gain_sticky <= 1'b0;
      end else begin
         if (set_sat) begin
            sat_sticky <= 1'b1;
         end else if (clr_sat) begin
            sat_sticky <= 1'b0;
         end
         if (set_zero) begin
            zero_gain_sticky <= 1'b1;
         end else if (clr_zero) begin
            zero_gain_sticky <= 1'b0;
         end
      end
   end

   // last corrected word, readable for calibration loops
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         last_result <= `AGOC_RESULT_MID;
      end else if (pipe_valid) begin
         last_result <= pipe_result;
      end
   end

   // ****************************************************************
   // register reads
   // ****************************************************************
   reg [31:0] next_rdata;

   // reserved and unmapped bits read as zero
   always @* begin
      next_rdata = 32'h00000000;
      if (hit_gain1) begin
         next_rdata[`AGOC_CAL_MSB:0] = aux_gain1_gain_cal;
      end else if (hit_off1) begin
         next_rdata[`AGOC_CAL_MSB:0] = aux_gain1_offset_cal;
      end else if (hit_off1p5) begin
         next_rdata[`AGOC_CAL_MSB:0] = aux_gain1p5_offset_cal;
      end else if (hit_status) begin
         next_rdata[15:0] = last_result;
         next_rdata[`AGOC_STAT_SAT_BIT] = sat_sticky;
         next_rdata[`AGOC_STAT_ZERO_GAIN_BIT] = zero_gain_sticky;
      end else if (hit_control) begin
         next_rdata[`AGOC_CTRL_EN_BIT] = corr_enable;
      end
   end

   // read data stands only in the cycle after the strobe
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // ****************************************************************
   // calibration selection
   // ****************************************************************
   // tia and temperature channels have their own calibration elsewhere,
   // so here they pass with zero offset and unity gain
   wire chan_aux = (raw_chan == `AGOC_CHAN_AUX);
   wire pga_is_1 = (raw_pga == `AGOC_PGA_1);
   wire pga_is_1p5 = (raw_pga == `AGOC_PGA_1P5);
   wire use_gain1 = corr_enable && chan_aux && pga_is_1;
   wire use_1p5 = corr_enable && chan_aux && pga_is_1p5;

   reg [14:0] sel_off;
   reg [14:0] sel_gain;

   // unity gain with zero offset reproduces the raw code exactly
   always @* begin
      sel_off = `AGOC_OFFSET_RESET;
      sel_gain = `AGOC_GAIN_UNITY;
      if (use_gain1) begin
         sel_off = aux_gain1_offset_cal;
         sel_gain = aux_gain1_gain_cal;
      end else if (use_1p5) begin
         sel_off = aux_gain1p5_offset_cal;
      end
   end

   // ****************************************************************
   // correction pipeline
   // ****************************************************************
   // offset codes map straight onto signed quarter lsbs, giving the
   // +4095.75 to -4096 span without any lookup
   agoc_correct u_correct (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .in_valid(raw_valid),
      .in_raw(raw_result),
      .in_off(sel_off),
      .in_gain(sel_gain),
      .out_valid(pipe_valid),
      .out_result(pipe_result),
      .out_sat(pipe_sat),
      .out_zero_gain(pipe_zero_gain)
   );

   // ****************************************************************
   // output stage
   // ****************************************************************
   // outputs follow the pipeline directly; valid is high for one cycle per sample, so back-to-back samples keep it high
   always @* begin
      conversion_result_valid = pipe_valid;
      conversion_result = pipe_result;
      conversion_saturated = pipe_valid && pipe_sat;
   end

endmodule

/* core/agoc_correct.v */
`timescale 1ns/1ps
`include "agoc_map.vh"

// two-stage offset and gain correction pipeline
module agoc_correct (
   // clock and reset
   input wire ref_clk,
   input wire resetn,
   // raw sample with chosen calibration
   input wire in_valid,
   input wire [15:0] in_raw,
   input wire [14:0] in_off,
   input wire [14:0] in_gain,
   // corrected sample
   output reg out_valid,
   output reg [15:0] out_result,
   output reg out_sat,
   output reg out_zero_gain
);

   // ****************************************************************
   // stage 1: centre the code and add the quarter-lsb offset
   // ****************************************************************
   // the offset field counts quarter lsbs, so the sample is scaled by four first
   wire signed [16:0] centered = $signed({1'b0, in_raw}) - $signed(17'h08000);
   wire signed [19:0] scaled = {centered[16], centered, 2'b00};
   wire signed [19:0] off_ext = {{5{in_off[`AGOC_CAL_MSB]}}, in_off};
   wire signed [19:0] next_sum = scaled + off_ext;

   reg s1_valid;
   reg signed [19:0] s1_sum;
   reg [14:0] s1_gain;

   // gain travels with its sample so a register write mid-flight cannot mix settings
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s1_valid <= 1'b0;
         s1_sum <= 20'sh00000;
         s1_gain <= `AGOC_GAIN_RESET;
      end else begin
         s1_valid <= in_valid;
         if (in_valid) begin
            s1_sum <= next_sum;
            s1_gain <= in_gain;
         end
      end
   end

   // ****************************************************************
   // stage 2: multiply by the q1.14 gain, round, re-bias, saturate
   // ****************************************************************
   wire signed [35:0] prod = s1_sum * $signed({1'b0, s1_gain});
   wire signed [35:0] rounded = prod + 36'sh000008000;
   wire signed [19:0] lsb = rounded[35:16];
   wire signed [20:0] biased = {lsb[19], lsb} + 21'sh08000;
   wire gain_zero = (s1_gain == 15'h0000);
   wire too_low = biased[20];
   wire too_high = !biased[20] && (biased > 21'sh0ffff);

   reg [15:0] next_result;
   reg next_sat;

   // clamp to the result word instead of wrapping round
   always @* begin
      next_sat = 1'b0;
      if (gain_zero) begin
         next_result = `AGOC_RESULT_MID;
      end else if (too_low) begin
         next_result = 16'h0000;
         next_sat = 1'b1;
      end else if (too_high) begin
         next_result = 16'hffff;
         next_sat = 1'b1;
      end else begin
         next_result = biased[15:0];
      end
   end

   // registered outputs
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         out_valid <= 1'b0;
         out_result <= `AGOC_RESULT_MID;
         out_sat <= 1'b0;
         out_zero_gain <= 1'b0;
      end else begin
         out_valid <= s1_valid;
         out_sat <= s1_valid && next_sat;
         out_zero_gain <= s1_valid && gain_zero;
         if (s1_valid) begin
            out_result <= next_result;
         end
      end
   end

endmodule

/* include/agoc_map.vh */
`ifndef AGOC_MAP_VH
`define AGOC_MAP_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define AGOC_ADDR_W 16
`define AGOC_OFS_GAIN1_GAIN 16'h2240
`define AGOC_OFS_GAIN1_OFFSET 16'h2244
`define AGOC_OFS_GAIN1P5_OFFSET 16'h22cc
`define AGOC_OFS_STATUS 16'h22d0
`define AGOC_OFS_CONTROL 16'h22d4

// ****************************************************************
// field layout
// ****************************************************************
`define AGOC_CAL_MSB 14
`define AGOC_CAL_W 15
`define AGOC_RES_W 16
`define AGOC_STAT_SAT_BIT 16
`define AGOC_STAT_ZERO_GAIN_BIT 17
`define AGOC_CTRL_EN_BIT 0

// ****************************************************************
// reset values and fixed codes
// ****************************************************************
`define AGOC_GAIN_RESET 15'h4000
`define AGOC_GAIN_UNITY 15'h4000
`define AGOC_OFFSET_RESET 15'h0000
`define AGOC_RESULT_MID 16'h8000
`define AGOC_CTRL_RESET 1'b1

// ****************************************************************
// channel classes and pga settings on the raw stream
// ****************************************************************
`define AGOC_CHAN_AUX 2'h0
`define AGOC_CHAN_HSTIA 2'h1
`define AGOC_CHAN_LPTIA 2'h2
`define AGOC_CHAN_TEMP 2'h3
`define AGOC_PGA_1 3'h0
`define AGOC_PGA_1P5 3'h1
`define AGOC_PGA_2 3'h2
`define AGOC_PGA_4 3'h3
`define AGOC_PGA_9 3'h4

// ****************************************************************
// timing
// ****************************************************************
`define AGOC_PIPE_CYCLES 2

`endif

/* test/adc_aux_gain_offset_correction_tb_top.sv */
`timescale 1ns/1ps
`include "agoc_map.vh"

// ********
// bench with an integer model of the correction
// ********
module adc_aux_gain_offset_correction_tb_top;
   reg ref_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, raw_valid = 0;
   reg [15:0] reg_addr = 0, raw_result = 16'h8000;
   reg [31:0] reg_wdata = 0;
   reg [1:0] raw_chan = 0;
   reg [2:0] raw_pga = 0;
   wire [31:0] reg_rdata;
   wire conversion_result_valid, conversion_saturated;
   wire [15:0] conversion_result;
   integer n_fail = 0, tests_run = 0, i, j;
   reg [14:0] g1 = 15'h4000, o1 = 0, o15 = 0;
   // bench view of the control enable and of the status word
   reg en = 1, ssee = 0, zsee = 0;
   reg [15:0] last_r = 16'h8000;
   reg [14:0] offs[0:4] = '{15'h3fff, 15'h0001, 15'h0000, 15'h7fff, 15'h4000};
   reg [14:0] gains[0:4] = '{15'h4000, 15'h2000, 15'h7fff, 15'h0001, 15'h0000};
   reg [16:0] expq[$];
   reg [16:0] e;
   reg [31:0] d;
   always #25 ref_clk = ~ref_clk;
   agoc_core dut_u (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .raw_valid(raw_valid),
      .raw_result(raw_result), .raw_chan(raw_chan), .raw_pga(raw_pga),
      .conversion_result_valid(conversion_result_valid), .conversion_result(conversion_result),
      .conversion_saturated(conversion_saturated));
   task summarize;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task check(input string what, input [31:0] seen, input [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // expected {saturated, result}; offset joins before the gain multiply
   function automatic [16:0] model(input [15:0] raw, input [1:0] ch, input [2:0] pg);
      longint s, y;
      reg [14:0] off, g;
      off = 0;
      g = 15'h4000;
      if (en && ch == `AGOC_CHAN_AUX && pg == `AGOC_PGA_1) begin
         off = o1;
         g = g1;
      end else if (en && ch == `AGOC_CHAN_AUX && pg == `AGOC_PGA_1P5) off = o15;
      s = 4 * (longint'(raw) - 32768) + longint'($signed(off));
      y = ((s * longint'(g) + 32768) >>> 16) + 32768;
      if (g == 0) model = 17'h08000;
      else if (y < 0) model = 17'h10000;
      else if (y > 65535) model = 17'h1ffff;
      else model = {1'b0, y[15:0]};
   endfunction
   // register master: one-cycle strobes, read data sampled mid-cycle after the strobe
   task wr(input [15:0] a, input [31:0] dat);
      @(posedge ref_clk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= dat;
      @(posedge ref_clk);
      reg_wr <= 0;
   endtask
   task rd(input string w, input [15:0] a, input [31:0] x);
      @(posedge ref_clk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 0;
      @(negedge ref_clk);
      check(w, reg_rdata, x);
   endtask
   // back-to-back samples, rails first so every gain-1 calibration that can saturate does so
   task smp(input integer n);
      reg [15:0] r;
      reg [1:0] c;
      reg [2:0] p;
      integer k;
      for (k = 0; k < n; k = k + 1) begin
         r = k == 0 ? 16'h0000 : k == 1 ? 16'hffff : $urandom;
         c = $urandom % 2 ? `AGOC_CHAN_AUX : $urandom % 4;
         p = $urandom % 2 ? $urandom % 2 : $urandom % 5;
         // with correction on, the rail samples go through the calibrated path so clamping is reached wherever the calibration allows it
         if (k < 2) begin
            c = `AGOC_CHAN_AUX;
            p = `AGOC_PGA_1;
         end
         if (en && c == `AGOC_CHAN_AUX && p == `AGOC_PGA_1 && g1 == 0) zsee = 1;
         @(posedge ref_clk);
         raw_valid <= 1;
         raw_result <= r;
         raw_chan <= c;
         raw_pga <= p;
         expq.push_back(model(r, c, p));
      end
      @(posedge ref_clk);
      raw_valid <= 0;
      repeat (4) @(posedge ref_clk);
   endtask
   // compare every corrected sample against the model queue
   always @(negedge ref_clk) begin
      if (conversion_result_valid === 1'b1) begin
         e = expq.pop_front();
         check("result", conversion_result, e[15:0]);
         check("saturated", conversion_saturated, e[16]);
         last_r = e[15:0];
         if (e[16]) ssee = 1;
      end
   end
   initial begin
      void'($urandom(42053));
      repeat (8) @(posedge ref_clk);
      resetn <= 1;
      rd("gain reset", `AGOC_OFS_GAIN1_GAIN, 32'h4000);
      rd("offset reset", `AGOC_OFS_GAIN1_OFFSET, 32'h0);
      rd("offset1p5 reset", `AGOC_OFS_GAIN1P5_OFFSET, 32'h0);
      rd("unmapped", 16'h2248, 32'h0);
      wr(`AGOC_OFS_GAIN1_OFFSET, 32'hffffffff);
      rd("offset reserved", `AGOC_OFS_GAIN1_OFFSET, 32'h7fff);
      $display("test registers done");
      // every listed offset code against every listed gain code
      for (i = 0; i < 5; i = i + 1) begin
         for (j = 0; j < 5; j = j + 1) begin
            o1 = offs[i];
            g1 = gains[j];
            d = $urandom;
            o15 = d[14:0];
            wr(`AGOC_OFS_GAIN1_OFFSET, {17'h0, o1});
            wr(`AGOC_OFS_GAIN1_GAIN, {17'h1ffff, g1});
            wr(`AGOC_OFS_GAIN1P5_OFFSET, d);
            smp(6);
         end
      end
      rd("gain readback", `AGOC_OFS_GAIN1_GAIN, {17'h0, g1});
      // correction switched off: every sample must pass untouched
      en = 0;
      wr(`AGOC_OFS_CONTROL, 32'h0);
      rd("control off", `AGOC_OFS_CONTROL, 32'h0);
      smp(6);
      en = 1;
      wr(`AGOC_OFS_CONTROL, 32'h1);
      rd("control on", `AGOC_OFS_CONTROL, 32'h1);
      // sticky flags and last result, then write-one-to-clear
      rd("status", `AGOC_OFS_STATUS, {14'h0, zsee, ssee, last_r});
      wr(`AGOC_OFS_STATUS, 32'h00030000);
      rd("status cleared", `AGOC_OFS_STATUS, {16'h0, last_r});
      $display("test control and status done");
      check("queue drained", expq.size(), 0);
      $display("test correction done");
      summarize;
   end
   // watchdog well beyond the expected run length
   initial begin
      #1000000;
      n_fail = n_fail + 1;
      summarize;
   end
endmodule

bind agoc_core agoc_checker chk_u (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .raw_valid(raw_valid), .raw_result(raw_result), .raw_chan(raw_chan), .raw_pga(raw_pga),
   .conversion_result_valid(conversion_result_valid), .conversion_result(conversion_result),
   .conversion_saturated(conversion_saturated));

/* test/agoc_checker.sv */
`timescale 1ns/1ps
`include "agoc_map.vh"

// ********
// port checker for the correction core
// ********
module agoc_checker (
   // clock and reset
   input wire ref_clk,
   input wire resetn,
   // register port
   input wire [15:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   // sample streams
   input wire raw_valid,
   input wire [15:0] raw_result,
   input wire [1:0] raw_chan,
   input wire [2:0] raw_pga,
   input wire conversion_result_valid,
   input wire [15:0] conversion_result,
   input wire conversion_saturated
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // status is left out: its flags sit above bit 15
   wire cal_adr = reg_addr == `AGOC_OFS_GAIN1_GAIN || reg_addr == `AGOC_OFS_GAIN1_OFFSET ||
                  reg_addr == `AGOC_OFS_GAIN1P5_OFFSET;
   wire mapped = cal_adr || reg_addr == `AGOC_OFS_STATUS || reg_addr == `AGOC_OFS_CONTROL;
   sequence s_bypass;
      raw_valid && (raw_chan != `AGOC_CHAN_AUX || raw_pga > `AGOC_PGA_1P5);
   endsequence
   sequence s_cal_read;
      reg_rd && cal_adr;
   endsequence
   sequence s_cal_write;
      reg_wr && cal_adr;
   endsequence
   // a calibration write read back two cycles later keeps only its low fifteen bits
   property p_wr_rd;
      s_cal_write ##1 !reg_wr ##1 (reg_rd && reg_addr == $past(reg_addr, 2)) |=>
         reg_rdata[14:0] == $past(reg_wdata[14:0], 3);
   endproperty
   a_wr_rd: assert property (p_wr_rd) else $error("calibration write not read back");
   property p_latency; raw_valid |-> ##2 conversion_result_valid; endproperty
   a_latency: assert property (p_latency) else $error("result strobe late");
   property p_no_spur; conversion_result_valid |-> $past(raw_valid, 2); endproperty
   a_no_spur: assert property (p_no_spur) else $error("result strobe without sample");
   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_rsv; s_cal_read |=> reg_rdata[31:15] == 17'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
   property p_unmapped; reg_rd && !mapped |=> reg_rdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_bypass;
      s_bypass |-> ##2 conversion_result == $past(raw_result, 2) && !conversion_saturated;
   endproperty
   a_bypass: assert property (p_bypass) else $error("uncalibrated sample altered");
   property p_sat_rail;
      conversion_saturated |-> conversion_result_valid && (conversion_result == 16'h0 || conversion_result == 16'hffff);
   endproperty
   a_sat_rail: assert property (p_sat_rail) else $error("saturation off the rails");
   property p_hold; !conversion_result_valid |-> $stable(conversion_result); endproperty
   a_hold: assert property (p_hold) else $error("result moved between strobes");
endmodule
